// *** xchg_flags_map.vh ***
`ifndef XCHG_FLAGS_MAP_VH
`define XCHG_FLAGS_MAP_VH
// register byte offsets
`define OFS_FLAGS       6'h00
`define OFS_MASK        6'h04
`define OFS_MODE        6'h08
`define OFS_XPTR        6'h0C
`define OFS_CLK_LOAD    6'h10
`define OFS_CLK_COUNT   6'h14
`define OFS_DBASE       6'h18
`define OFS_DLIMIT      6'h1C
`define OFS_IBASE       6'h20
`define OFS_ILIMIT      6'h24
`define OFS_PADDR       6'h28
`define OFS_CTX         6'h2C
`define OFS_IRQ_STAT    6'h30
`define OFS_IRQ_MASK    6'h34
// flag bit positions
`define FLG_NEX         0
`define FLG_ORE         1
`define FLG_PRE         2
`define FLG_PCI         3
`define FLG_ME          4
`define FLG_EEX         5
`define FLG_ICP         6
`define FLG_IOI         7
`define FLG_MCU         8
`define FLG_W           9
// mode bit positions
`define MOD_MON         0
`define MOD_IMM         1
`define MOD_IOR         2
`define MOD_SEI         3
`define MOD_EAM         4
// context bit positions
`define CTX_WS          0
`define CTX_VNU         1
`define CTX_RMODE_LO    2
`define CTX_RMODE_W     2
`define CTX_PN_LO       8
// reset values
`define RST_MODE        5'h01
`define RST_ZERO32      32'h00000000
`define RST_CTX_VNU     1'b1
// irq status bit positions
`define IST_FLAG        0
`define IST_XCHG        1
`define IST_W           2
`define XPKG_WORDS      5'h10
`endif

// *** range_check.v ***
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// address window check with width selection
// ************************************************************
module range_check
(
    // address and window
    input  wire [31:0] addr,
    input  wire [31:0] base,
    input  wire [31:0] limit,
    // width select
    input  wire        wide,
    // result
    output wire        outside
);
    wire [31:0] a;
    wire [31:0] b;
    wire [31:0] l;
    // narrow mode keeps only low 24 bits
    assign a = wide ? addr  : {8'h00, addr[23:0]};
    assign b = wide ? base  : {8'h00, base[23:0]};
    assign l = wide ? limit : {8'h00, limit[23:0]};
    assign outside = (a < b) || (a >= l);
endmodule
`default_nettype wire

// *** interval_clock.v ***
`timescale 1ns/10ps
`default_nettype none
`include "xchg_flags_map.vh"
// ************************************************************
// programmable interval countdown
// ************************************************************
module interval_clock
(
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // control
    input  wire        load,
    input  wire [31:0] load_value,
    // status
    output reg  [31:0] count,
    output reg         expired
);
    always @(posedge clk)
    begin
        if (reset)
        begin
            count   <= `RST_ZERO32;
            expired <= 1'b0;
        end
        else if (load)
        begin
            count   <= load_value;
            expired <= 1'b0;
        end
        else if (count != 32'h00000000)
        begin
            count   <= count - 32'h00000001;
            expired <= (count == 32'h00000001);
        end
        else
        begin
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** xchg_flags.v ***
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "xchg_flags_map.vh"
// ************************************************************
// cpu interrupt flags and exchange state
// ************************************************************
module xchg_flags
#(
    parameter [3:0] CPU_ID = 4'h0
)
(
    // clock and reset
    input  wire        CLK,
    input  wire        RESET,
    // wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [5:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O,
    // issue events
    input  wire        NEX_EXEC,
    input  wire        EEX_EXEC,
    input  wire        DATA_REF,
    input  wire [31:0] DATA_ADDR,
    input  wire        FETCH,
    input  wire [31:0] FETCH_ADDR,
    input  wire        MEM_ERR,
    input  wire [1:0]  MEM_READ_MODE,
    input  wire        ICP_REQ,
    input  wire        IOI_REQ,
    input  wire        MCU_REQ,
    input  wire        VEC_ISSUE,
    input  wire        TAS_WAITING,
    input  wire [31:0] P_CURRENT,
    // exchange sequencing
    input  wire        XCHG_DONE,
    // outputs to issue logic
    output wire        PROG_INTERRUPT,
    output wire        WIDE_ADDR,
    output wire        THREE_PARCEL_OK,
    output wire        PREFERRED_EXT,
    output wire [31:0] RESUME_P,
    output wire [31:0] XPKG_ADDR,
    output wire        IRQ
);
    reg  [9:0]  flags;
    reg  [4:0]  mode;
    reg  [31:0] xptr;
    reg  [31:0] clk_load;
    reg  [31:0] dbase;
    reg  [31:0] dlimit;
    reg  [31:0] ibase;
    reg  [31:0] ilimit;
    reg  [31:0] paddr;
    reg         ws;
    reg         vector_unused_bit;
    reg  [1:0]  rmode;
    reg  [2:0]  ist;
    reg  [2:0]  imask;
    reg         clk_ld;
    reg  [9:0]  next_set;
    reg  [31:0] rdata;
    wire        req;
    wire        wr;
    wire        rd;
    wire [31:0] wmask;
    wire        ore_out;
    wire        pre_out;
    wire [31:0] clk_count;
    wire        clk_exp;
    wire        mon;
    wire        irq_in_monitor_enable;

    assign req  = CYC_I & STB_I & ~ACK_O;
    assign wr   = req & WE_I;
    assign rd   = req & ~WE_I;
    assign mon  = mode[`MOD_MON];
    assign irq_in_monitor_enable  = mode[`MOD_IMM];
    assign wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

    // ************************************************************
    // submodules
    // ************************************************************
    range_check u_data
    (
        .addr    (DATA_ADDR),
        .base    (dbase),
        .limit   (dlimit),
        .wide    (mode[`MOD_EAM]),
        .outside (ore_out)
    );
    range_check u_fetch
    (
        .addr    (FETCH_ADDR),
        .base    (ibase),
        .limit   (ilimit),
        .wide    (mode[`MOD_EAM]),
        .outside (pre_out)
    );
    interval_clock u_clk
    (
        .clk        (CLK),
        .reset      (RESET),
        .load       (clk_ld),
        .load_value (clk_load),
        .count      (clk_count),
        .expired    (clk_exp)
    );

    // ************************************************************
    // flag set conditions
    // ************************************************************
    always @*
    begin
        next_set = 10'h000;
        next_set[`FLG_NEX] = NEX_EXEC & (~mon | ~irq_in_monitor_enable);
        next_set[`FLG_EEX] = EEX_EXEC;
        next_set[`FLG_ME]  = MEM_ERR;
        next_set[`FLG_ORE] = DATA_REF & ore_out & mode[`MOD_IOR];
        next_set[`FLG_PRE] = FETCH & pre_out;
        next_set[`FLG_PCI] = clk_exp;
        next_set[`FLG_ICP] = ICP_REQ;
        next_set[`FLG_IOI] = IOI_REQ;
        next_set[`FLG_MCU] = MCU_REQ;
        if (mon && !irq_in_monitor_enable)
        begin
            next_set[`FLG_ORE] = 1'b0;
            next_set[`FLG_PRE] = 1'b0;
            next_set[`FLG_PCI] = 1'b0;
            next_set[`FLG_ICP] = 1'b0;
            next_set[`FLG_IOI] = 1'b0;
            next_set[`FLG_MCU] = 1'b0;
        end
        if (mon && irq_in_monitor_enable)
        begin
            next_set[`FLG_PCI] = 1'b0;
            next_set[`FLG_MCU] = 1'b0;
            next_set[`FLG_ICP] = 1'b0;
            next_set[`FLG_IOI] = 1'b0;
        end
    end

    // ************************************************************
    // flags, context and registers
    // ************************************************************
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            flags    <= 10'h000;
            mode     <= `RST_MODE;
            xptr     <= `RST_ZERO32;
            clk_load <= `RST_ZERO32;
            dbase    <= `RST_ZERO32;
            dlimit   <= `RST_ZERO32;
            ibase    <= `RST_ZERO32;
            ilimit   <= `RST_ZERO32;
            paddr    <= `RST_ZERO32;
            ws       <= 1'b0;
            vector_unused_bit      <= `RST_CTX_VNU;
            rmode    <= 2'h0;
            clk_ld   <= 1'b0;
        end
        else
        begin
            clk_ld <= wr && (ADR_I == `OFS_CLK_LOAD);
            if (XCHG_DONE)
            begin
                flags <= next_set;
                ws    <= TAS_WAITING;
                paddr <= P_CURRENT;
                vector_unused_bit   <= `RST_CTX_VNU;
            end
            else
            begin
                flags <= flags | next_set;
                if (VEC_ISSUE)
                    vector_unused_bit <= 1'b0;
            end
            if (MEM_ERR)
                rmode <= MEM_READ_MODE;
            if (wr)
            begin
                case (ADR_I)
                    `OFS_MODE:     mode     <= DAT_I[4:0];
                    `OFS_XPTR:     xptr     <= (xptr & ~wmask) | (DAT_I & wmask);
                    `OFS_CLK_LOAD: clk_load <= (clk_load & ~wmask) | (DAT_I & wmask);
                    `OFS_DBASE:    dbase    <= (dbase & ~wmask) | (DAT_I & wmask);
                    `OFS_DLIMIT:   dlimit   <= (dlimit & ~wmask) | (DAT_I & wmask);
                    `OFS_IBASE:    ibase    <= (ibase & ~wmask) | (DAT_I & wmask);
                    `OFS_ILIMIT:   ilimit   <= (ilimit & ~wmask) | (DAT_I & wmask);
                    `OFS_PADDR:    paddr    <= (paddr & ~wmask) | (DAT_I & wmask);
                    default:       ;
                endcase
            end
        end
    end

    // ************************************************************
    // interrupt status, mask and bus answer
    // ************************************************************
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            ist   <= 3'h0;
            imask <= 3'h0;
            ACK_O <= 1'b0;
            DAT_O <= `RST_ZERO32;
        end
        else
        begin
            ACK_O <= req;
            if (rd)
                DAT_O <= rdata;
            if (wr && ADR_I == `OFS_IRQ_MASK)
                imask <= DAT_I[2:0];
            // set wins over read clear
            ist <= ((rd && ADR_I == `OFS_IRQ_STAT) ? 3'h0 : ist)
                 | {1'b0, XCHG_DONE, |next_set};
        end
    end

    // read multiplexer
    always @*
    begin
        case (ADR_I)
            `OFS_FLAGS:     rdata = {22'h000000, flags};
            `OFS_MODE:      rdata = {27'h0000000, mode};
            `OFS_XPTR:      rdata = xptr;
            `OFS_CLK_LOAD:  rdata = clk_load;
            `OFS_CLK_COUNT: rdata = clk_count;
            `OFS_DBASE:     rdata = dbase;
            `OFS_DLIMIT:    rdata = dlimit;
            `OFS_IBASE:     rdata = ibase;
            `OFS_ILIMIT:    rdata = ilimit;
            `OFS_PADDR:     rdata = paddr;
            `OFS_CTX:       rdata = {20'h00000, CPU_ID, 4'h0, rmode, vector_unused_bit, ws};
            `OFS_IRQ_STAT:  rdata = {29'h00000000, ist};
            `OFS_IRQ_MASK:  rdata = {29'h00000000, imask};
            default:        rdata = 32'h00000000;
        endcase
    end

    assign PROG_INTERRUPT  = |flags;
    assign WIDE_ADDR       = mode[`MOD_EAM];
    assign THREE_PARCEL_OK = mode[`MOD_EAM];
    assign PREFERRED_EXT   = mode[`MOD_SEI];
    assign RESUME_P        = paddr;
    assign XPKG_ADDR       = xptr;
    assign IRQ             = |(ist & imask);
endmodule
`default_nettype wire

// *** xchg_flags_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// bus, flag and mode checks
// ********
module xchg_flags_asserts
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // bus
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic        ACK_O,
    // events
    input wire logic        NEX_EXEC,
    input wire logic        EEX_EXEC,
    input wire logic        MEM_ERR,
    input wire logic        ICP_REQ,
    input wire logic        IOI_REQ,
    input wire logic        MCU_REQ,
    input wire logic        DATA_REF,
    input wire logic        FETCH,
    input wire logic        XCHG_DONE,
    // outputs
    input wire logic        PROG_INTERRUPT,
    input wire logic        WIDE_ADDR,
    input wire logic        THREE_PARCEL_OK,
    input wire logic        PREFERRED_EXT,
    input wire logic [31:0] RESUME_P
);
    // any flag source this cycle except the interval clock, and a write on the bus
    wire logic ev = NEX_EXEC | EEX_EXEC | MEM_ERR | ICP_REQ | IOI_REQ | MCU_REQ | DATA_REF | FETCH;
    wire logic wr = CYC_I & WE_I;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // bus answer timing
    a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acknowledged");
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack held too long");
    a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    // flag behaviour
    a_exit_passes: assert property (EEX_EXEC || MEM_ERR |=> PROG_INTERRUPT)
        else $error("exit or memory error did not interrupt");
    a_flag_hold: assert property (PROG_INTERRUPT && !XCHG_DONE |=> PROG_INTERRUPT)
        else $error("flag dropped before exchange");
    a_xchg_clears: assert property (XCHG_DONE && !ev |=> !PROG_INTERRUPT)
        else $error("flags survived exchange");
    // mode outputs, resume address and reset state
    a_parcel_wide: assert property (THREE_PARCEL_OK == WIDE_ADDR)
        else $error("parcel and width disagree");
    a_mode_write: assert property (!$stable({WIDE_ADDR, PREFERRED_EXT}) |-> wr || $past(wr))
        else $error("mode changed without write");
    a_resume_src: assert property (!$stable(RESUME_P) |-> wr || $past(wr) || $past(XCHG_DONE))
        else $error("program address changed unprompted");
    a_reset_narrow: assert property ($fell(RESET) |-> !WIDE_ADDR && !PROG_INTERRUPT)
        else $error("reset state wrong");
endmodule
bind xchg_flags xchg_flags_asserts u_chk
(
    .CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ACK_O(ACK_O),
    .NEX_EXEC(NEX_EXEC), .EEX_EXEC(EEX_EXEC), .MEM_ERR(MEM_ERR), .ICP_REQ(ICP_REQ),
    .IOI_REQ(IOI_REQ), .MCU_REQ(MCU_REQ), .DATA_REF(DATA_REF), .FETCH(FETCH),
    .XCHG_DONE(XCHG_DONE), .PROG_INTERRUPT(PROG_INTERRUPT), .WIDE_ADDR(WIDE_ADDR),
    .THREE_PARCEL_OK(THREE_PARCEL_OK), .PREFERRED_EXT(PREFERRED_EXT), .RESUME_P(RESUME_P)
);
`default_nettype wire

// *** issue_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// exchange sequencer stand-in
// ********
module issue_model
(
    // clock and request
    input wire logic        clk,
    input wire logic        start,
    input wire logic        tas,
    input wire logic [2:0]  dly,
    input wire logic [31:0] p,
    // toward the block
    output logic            xchg_done = 1'b0,
    output logic            tas_waiting = 1'b0,
    output logic [31:0]     p_current = 32'h0
);
    logic [2:0] cnt = 3'h0;
    // done pulses dly cycles after start; address goes stale once done is taken
    always @(posedge clk)
    begin
        xchg_done <= (cnt == 3'h1) && !start;
        if (start)
        begin
            cnt <= dly;
            tas_waiting <= tas;
            p_current <= p;
        end
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
        if (xchg_done)
            p_current <= ~p_current;
    end
endmodule
`default_nettype wire

// *** cpu_interrupt_flag_and_exchange_state_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end
// ********
// bench top
// ********
module cpu_interrupt_flag_and_exchange_state_test;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        go = 1'b0, tas = 1'b0, ack, pint, wide, tp, pref, irq, xd, tw;
    logic [1:0]  rm = 2'h0;
    logic [2:0]  dly = 3'h1;
    logic [5:0]  adr = 6'h0;
    logic [8:0]  ev = 9'h0;
    logic [31:0] wd = 32'h0, da = 32'h0, fa = 32'h0, pp = 32'h0, r, dat_o, resume, xpkg, pc;
    int          fails = 0, samples_checked = 0, n;
    always #10 clk = ~clk;
    // cpu id value is arbitrary
    xchg_flags #(.CPU_ID(4'h5)) u_dut
    (
        .CLK(clk), .RESET(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(wd), .DAT_O(dat_o), .ACK_O(ack), .NEX_EXEC(ev[0]),
        .EEX_EXEC(ev[1]), .MEM_ERR(ev[2]), .ICP_REQ(ev[3]), .IOI_REQ(ev[4]),
        .MCU_REQ(ev[5]), .VEC_ISSUE(ev[6]), .DATA_REF(ev[7]), .DATA_ADDR(da),
        .FETCH(ev[8]), .FETCH_ADDR(fa), .MEM_READ_MODE(rm), .TAS_WAITING(tw),
        .P_CURRENT(pc), .XCHG_DONE(xd), .PROG_INTERRUPT(pint), .WIDE_ADDR(wide),
        .THREE_PARCEL_OK(tp), .PREFERRED_EXT(pref), .RESUME_P(resume),
        .XPKG_ADDR(xpkg), .IRQ(irq)
    );
    issue_model u_seq
    (
        .clk(clk), .start(go), .tas(tas), .dly(dly), .p(pp),
        .xchg_done(xd), .tas_waiting(tw), .p_current(pc)
    );
    // closing report
    task automatic conclude();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle, read data kept in r
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        r = dat_o;
        {cyc, stb, we} <= 3'h0;
        if (n == 20)
        begin
            fails++;
            conclude();
        end
    endtask
    // one-cycle event pulse
    task automatic pulse(input logic [8:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 9'h0;
    endtask
    // exchange through the sequencer
    task automatic xchg(input logic t, input logic [31:0] p, input logic [2:0] dl);
        @(posedge clk);
        {go, tas, pp, dly} <= {1'b1, t, p, dl};
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (xd !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
        begin
            fails++;
            conclude();
        end
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rm <= 2'h2;
        bus(0, 6'h08, 32'h0); `CHK(r, 32'h1)
        bus(0, 6'h2C, 32'h0); `CHK(r, 32'h502)
        `CHK(wide, 1'b0)
        pulse(9'h038); pulse(9'h001); pulse(9'h002); pulse(9'h004);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h31)
        `CHK(pint, 1'b1)
        bus(0, 6'h2C, 32'h0); `CHK(r[3:0], 4'hA)
        pulse(9'h040); bus(0, 6'h2C, 32'h0); `CHK(r[1], 1'b0)
        xchg(1'b1, 32'h1234, 3'h3);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h0)
        `CHK(resume, 32'h1234)
        bus(0, 6'h2C, 32'h0); `CHK(r[1:0], 2'h3)
        bus(1, 6'h34, 32'h0); bus(0, 6'h34, 32'h0); `CHK(irq, 1'b0)
        bus(1, 6'h34, 32'h3); bus(0, 6'h34, 32'h0); `CHK(irq, 1'b1)
        bus(0, 6'h30, 32'h0); `CHK(r[1:0], 2'h3)
        bus(0, 6'h30, 32'h0); `CHK(r, 32'h0)
        `CHK(irq, 1'b0)
        $display("test monitor, exchange, interrupt done");
        bus(1, 6'h08, 32'h4); pulse(9'h038); pulse(9'h001);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h1C1)
        xchg(1'b0, 32'h40, 3'h1); bus(0, 6'h2C, 32'h0); `CHK(r[0], 1'b0)
        bus(1, 6'h08, 32'h3); pulse(9'h03B);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h20)
        xchg(1'b0, 32'h0, 3'h1);
        $display("test mode masking done");
        bus(1, 6'h08, 32'h4); bus(1, 6'h18, 32'h100); bus(1, 6'h1C, 32'h200);
        da <= 32'h1FF; pulse(9'h080); da <= 32'h1000150; pulse(9'h080);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h0)
        da <= 32'h200; pulse(9'h080);
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h2)
        xchg(1'b0, 32'h0, 3'h1);
        bus(1, 6'h08, 32'h18); `CHK({wide, tp}, 2'h3)
        `CHK(pref, 1'b1)
        da <= 32'h1000150; pulse(9'h080); bus(1, 6'h20, 32'h100); bus(1, 6'h24, 32'h200);
        fa <= 32'hFF; pulse(9'h100); fa <= 32'h100; pulse(9'h100);
        bus(1, 6'h0C, 32'hA00); `CHK(xpkg, 32'hA00)
        bus(1, 6'h00, 32'hFF); bus(1, 6'h38, 32'h5); bus(0, 6'h38, 32'h0); `CHK(r, 32'h0)
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h4)
        xchg(1'b0, 32'h0, 3'h1);
        $display("test windows done");
        bus(1, 6'h10, 32'hFFFFFFF0); bus(0, 6'h14, 32'h0); `CHK(r[31:8], 24'hFFFFFF)
        bus(1, 6'h10, 32'h5);
        n = 0;
        while (pint !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(pint, 1'b1)
        bus(0, 6'h00, 32'h0); `CHK(r, 32'h8)
        $display("test interval clock done");
        conclude();
    end
endmodule
`default_nettype wire
